// >>> verilog/lgd_pkg.sv
// Constants, enums and timing figures for the four-common LCD glass drive.
// Assumes one 200 MHz clock; every input of the block comes from logic on that clock.
// Function
// - Accept a 16-bit contrast setting, 0 up to 0x1CB8, as dead-time length.
// - Contrast zero gives full duty: drive active for the whole period.
// - Contrast at maximum gives zero duty with dead time after every period: the glass stays transparent.
// - Contrast sets the dead-time compare; its match ends active drive.
// - Dead time goes after every period or once per frame, selectable.
// - Longer dead time lowers rms voltage, shorter raises it.
// - Segment and common pulses stay exactly equal in width.
// - Segments and commons update on the same clock edge, never apart.
// - Low power switches the bias supply off and drives all lines to 0 V.
// - Phase compare alternates two sub-tasks chosen by a phase-select flag.
// - Four commons stepped in fixed order; segments grouped four per digit.
// - Phase compare recurs every 3.6 ms and moves to the next phase.
// - A dead-time compare after each phase compare, or only in the last phase of a frame in frame mode, switches drive off.
package lgd_pkg;
	localparam int          LGD_NUM_COM         = 4;
	localparam int          LGD_SEGS_PER_DIGIT  = 4;
	localparam int          LGD_NUM_DIGIT       = 8;
	localparam int          LGD_NUM_SEG         = LGD_NUM_DIGIT * LGD_SEGS_PER_DIGIT;
	localparam int          LGD_PAT_W           = LGD_NUM_COM * LGD_NUM_SEG;
	localparam int          LGD_TICK_W          = 16;
	localparam int          LGD_PRESC_W         = 20;
	localparam logic [15:0] LGD_CONTRAST_MAX    = 16'h1CB8;
	localparam logic [15:0] LGD_CONTRAST_RST    = 16'h0000;
	localparam logic [1:0]  LGD_COM_FIRST       = 2'h0;
	localparam logic [1:0]  LGD_COM_LAST        = 2'h3;
	localparam logic [1:0]  LGD_COM_STEP        = 2'h1;
	// Phase compare period and clock period, both in ns
	localparam int          LGD_PHASE_PERIOD_NS = 3600000;
	localparam int          LGD_CLK_PERIOD_NS   = 5;
	localparam int          LGD_PHASE_CYC       = LGD_PHASE_PERIOD_NS / LGD_CLK_PERIOD_NS;

	typedef enum logic [1:0]
	{
		LGD_ST_OFF    = 2'b00,
		LGD_ST_ACTIVE = 2'b01,
		LGD_ST_DEAD   = 2'b11
	} lgd_drive_t;

	typedef enum logic
	{
		LGD_SUB_FIRST  = 1'b0,
		LGD_SUB_SECOND = 1'b1
	} lgd_sub_t;
endpackage

// >>> verilog/lgd_phase_timer.sv
// Prescaled period timer: one phase compare per period, tick count for the dead-time compare.
// Assumes P_PRESC is at least one; the period is P_PRESC times the contrast range in cycles.
`timescale 1ns/1ps
module lgd_phase_timer
#(
	parameter int P_PRESC = 1
)
(
	// Clock and reset
	input  wire logic                            i_clk,
	input  wire logic                            i_rst_n,
	// Control
	input  wire logic                            i_run,
	// Timer state
	output logic      [lgd_pkg::LGD_TICK_W-1:0]  o_tick,
	output logic                                 o_phase_compare
);
	import lgd_pkg::*;

	localparam logic [LGD_PRESC_W-1:0] PRESC_LAST = LGD_PRESC_W'(P_PRESC - 1);
	localparam logic [LGD_TICK_W-1:0]  TICK_LAST  = LGD_CONTRAST_MAX - 16'h0001;

	logic [LGD_PRESC_W-1:0] presc_q;
	logic [LGD_PRESC_W-1:0] presc_d;
	logic [LGD_TICK_W-1:0]  tick_q;
	logic [LGD_TICK_W-1:0]  tick_d;
	logic                   pc_q;
	logic                   pc_d;

	always_comb
	begin
		presc_d = presc_q;
		tick_d  = tick_q;
		pc_d    = 1'b0;
		if (!i_run)
		begin
			presc_d = '0;
			tick_d  = '0;
		end
		else if (presc_q == PRESC_LAST)
		begin
			presc_d = '0;
			if (tick_q == TICK_LAST)
			begin
				// Pulse lands with tick back at zero, so the new period starts on it
				tick_d = '0;
				pc_d   = 1'b1;
			end
			else
			begin
				tick_d = tick_q + 16'h0001;
			end
		end
		else
		begin
			presc_d = presc_q + LGD_PRESC_W'(1);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			presc_q <= '0;
			tick_q  <= '0;
			pc_q    <= 1'b0;
		end
		else
		begin
			presc_q <= presc_d;
			tick_q  <= tick_d;
			pc_q    <= pc_d;
		end
	end

	assign o_tick          = tick_q;
	assign o_phase_compare = pc_q;
endmodule

// >>> verilog/lgd_glass_drive.sv
// Top of the four-common LCD glass drive: phase sequencing, dead-time contrast, low-power shutdown.
// Assumes external bias resistors hold undriven commons at mid level; all inputs are on i_clk.
`timescale 1ns/1ps
module lgd_glass_drive
#(
	parameter int P_PHASE_CYC = lgd_pkg::LGD_PHASE_CYC
)
(
	// Clock and reset
	input  wire logic                              i_clk,
	input  wire logic                              i_rst_n,
	// Control
	input  wire logic [15:0]                       i_contrast_setting,
	input  wire logic                              i_dead_at_frame_end,
	input  wire logic                              i_low_power,
	input  wire logic [lgd_pkg::LGD_PAT_W-1:0]     i_seg_pattern,
	// Glass lines
	output logic      [lgd_pkg::LGD_NUM_SEG-1:0]   o_seg,
	output logic      [lgd_pkg::LGD_NUM_COM-1:0]   o_com,
	output logic      [lgd_pkg::LGD_NUM_COM-1:0]   o_com_oe,
	output logic                                   o_glass_bias_supply,
	// Status
	output logic                                   o_phase_select_flag,
	output logic      [1:0]                        o_common_index,
	output logic                                   o_dead_time
);
	import lgd_pkg::*;

	// Truncating division: the period comes out at most one prescale step short
	localparam int PRESC = (P_PHASE_CYC / int'(LGD_CONTRAST_MAX)) < 1 ? 1
	                     : (P_PHASE_CYC / int'(LGD_CONTRAST_MAX));

	logic [LGD_TICK_W-1:0] tick;
	logic                  phase_compare;

	lgd_phase_timer #(
		.P_PRESC         (PRESC)
	) u_timer (
		.i_clk           (i_clk),
		.i_rst_n         (i_rst_n),
		.i_run           (!i_low_power),
		.o_tick          (tick),
		.o_phase_compare (phase_compare)
	);

	// Phase sequencing state
	lgd_sub_t    sub_q;
	lgd_sub_t    sub_d;
	logic [1:0]  com_q;
	logic [1:0]  com_d;
	logic [15:0] contrast_q;
	logic [15:0] contrast_d;
	logic        frame_mode_q;
	logic        frame_mode_d;

	always_comb
	begin
		sub_d        = sub_q;
		com_d        = com_q;
		contrast_d   = contrast_q;
		frame_mode_d = frame_mode_q;
		if (i_low_power)
		begin
			// Restart cleanly from the first common on wake-up
			sub_d = LGD_SUB_FIRST;
			com_d = LGD_COM_FIRST;
		end
		else if (phase_compare)
		begin
			// Settings sampled only here, so a period never changes length midway
			contrast_d   = (i_contrast_setting > LGD_CONTRAST_MAX) ? LGD_CONTRAST_MAX
			             : i_contrast_setting;
			frame_mode_d = i_dead_at_frame_end;
			if (sub_q == LGD_SUB_FIRST)
			begin
				sub_d = LGD_SUB_SECOND;
			end
			else
			begin
				sub_d = LGD_SUB_FIRST;
				com_d = (com_q == LGD_COM_LAST) ? LGD_COM_FIRST : com_q + LGD_COM_STEP;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sub_q        <= LGD_SUB_FIRST;
			com_q        <= LGD_COM_FIRST;
			contrast_q   <= LGD_CONTRAST_RST;
			frame_mode_q <= 1'b0;
		end
		else
		begin
			sub_q        <= sub_d;
			com_q        <= com_d;
			contrast_q   <= contrast_d;
			frame_mode_q <= frame_mode_d;
		end
	end

	// Drive state, judged from the next sequencing values so the new pattern starts on the compare
	lgd_drive_t            drive_st;
	logic [LGD_TICK_W-1:0] active_len;
	logic                  last_phase;
	logic                  dead_hit;

	always_comb
	begin
		active_len = LGD_CONTRAST_MAX - contrast_d;
		last_phase = (com_d == LGD_COM_LAST) && (sub_d == LGD_SUB_SECOND);
		// Tick wraps at the phase compare, so dead time ends there for any contrast below maximum
		dead_hit   = (tick >= active_len) && (!frame_mode_d || last_phase);
		if (i_low_power)
		begin
			drive_st = LGD_ST_OFF;
		end
		else if (dead_hit)
		begin
			drive_st = LGD_ST_DEAD;
		end
		else
		begin
			drive_st = LGD_ST_ACTIVE;
		end
	end

	// Output registers: segments and commons share one edge
	logic [LGD_NUM_SEG-1:0] seg_q;
	logic [LGD_NUM_SEG-1:0] seg_d;
	logic [LGD_NUM_COM-1:0] com_out_q;
	logic [LGD_NUM_COM-1:0] com_out_d;
	logic [LGD_NUM_COM-1:0] com_oe_q;
	logic [LGD_NUM_COM-1:0] com_oe_d;
	logic                   bias_q;
	logic                   bias_d;
	logic                   dead_q;
	logic                   dead_d;
	logic [LGD_NUM_SEG-1:0] pat;

	always_comb
	begin
		pat       = i_seg_pattern[com_d * LGD_NUM_SEG +: LGD_NUM_SEG];
		seg_d     = '0;
		com_out_d = '0;
		com_oe_d  = '1;
		bias_d    = 1'b1;
		dead_d    = 1'b0;
		unique case (drive_st)
			LGD_ST_OFF:
			begin
				bias_d = 1'b0;
			end
			LGD_ST_DEAD:
			begin
				dead_d = 1'b1;
			end
			LGD_ST_ACTIVE:
			begin
				// Both halves last one full period each, so the net DC cancels when both get the same dead time
				com_oe_d = '0;
				com_oe_d[com_d] = 1'b1;
				if (sub_d == LGD_SUB_FIRST)
				begin
					com_out_d[com_d] = 1'b1;
					seg_d = ~pat;
				end
				else
				begin
					com_out_d[com_d] = 1'b0;
					seg_d = pat;
				end
			end
			default:
			begin
				bias_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			seg_q     <= '0;
			com_out_q <= '0;
			com_oe_q  <= '1;
			bias_q    <= 1'b0;
			dead_q    <= 1'b0;
		end
		else
		begin
			seg_q     <= seg_d;
			com_out_q <= com_out_d;
			com_oe_q  <= com_oe_d;
			bias_q    <= bias_d;
			dead_q    <= dead_d;
		end
	end

	assign o_seg               = seg_q;
	assign o_com               = com_out_q;
	assign o_com_oe            = com_oe_q;
	assign o_glass_bias_supply = bias_q;
	assign o_dead_time         = dead_q;
	assign o_phase_select_flag = sub_q;
	assign o_common_index      = com_q;
endmodule

// >>> testbench/lgd_glass_drive_properties.sv
// Port-level checks for the glass drive.
// Assumes one clock domain; bound into every drive instance.
`timescale 1ns/1ps
module lgd_glass_drive_checker
#(
	parameter int P_PHASE_CYC = 7352
)
(
	// Inputs
	input wire logic                     i_clk,
	input wire logic                     i_rst_n,
	input wire logic                     i_low_power,
	input wire logic [lgd_pkg::LGD_PAT_W-1:0] i_seg_pattern,
	// Outputs
	input wire logic [31:0]              o_seg,
	input wire logic [3:0]               o_com,
	input wire logic [3:0]               o_com_oe,
	input wire logic                     o_glass_bias_supply,
	input wire logic                     o_phase_select_flag,
	input wire logic [1:0]               o_common_index,
	input wire logic                     o_dead_time
);
	import lgd_pkg::*;
	localparam int PRE = (P_PHASE_CYC / 7352 < 1) ? 1 : P_PHASE_CYC / 7352;
	localparam int PER = PRE * 7352;
	int          cnt_q;
	logic        seen_q;
	logic [31:0] pat0_q;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Left unreset so the first cycle after release already compares
	always_ff @(posedge i_clk)
		pat0_q <= i_seg_pattern[31:0];
	always_ff @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n)
			seen_q <= 1'b0;
		else if (i_low_power)
			seen_q <= 1'b0;
		else if ($changed(o_phase_select_flag))
			seen_q <= !$past(i_low_power);
	always_ff @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n)
			cnt_q <= 0;
		else if ($changed(o_phase_select_flag))
			cnt_q <= 0;
		else
			cnt_q <= cnt_q + 1;
	a_low_power_off: assert property (i_low_power |=> !o_glass_bias_supply && o_seg == '0 && o_com == '0 && &o_com_oe)
		else $error("lines not off in low power");
	a_bias_follows: assert property (!i_low_power |=> o_glass_bias_supply)
		else $error("bias supply off while running");
	a_dead_lines_zero: assert property (o_dead_time |-> o_seg == '0 && o_com == '0 && &o_com_oe)
		else $error("drive left on in dead time");
	a_single_common: assert property (o_glass_bias_supply && $past(o_glass_bias_supply) && !o_dead_time |-> $onehot(o_com_oe))
		else $error("not one common driven");
	a_first_polarity: assert property (!o_dead_time && o_com_oe == 4'h1 && o_com == 4'h1 |-> o_seg == ~pat0_q)
		else $error("first sub-task segment mismatch");
	a_phase_period: assert property ($changed(o_phase_select_flag) && seen_q && !$past(i_low_power) |-> cnt_q == PER - 1)
		else $error("phase period wrong");
	a_index_step: assert property ($changed(o_common_index) && !$past(i_low_power) |-> o_common_index == $past(o_common_index) + 2'h1 && !o_phase_select_flag && $past(o_phase_select_flag))
		else $error("common order wrong");
	a_swap_same_edge: assert property (!o_dead_time && !$past(o_dead_time) && o_com_oe == $past(o_com_oe) && o_com != $past(o_com) && $past(i_seg_pattern) == $past(i_seg_pattern, 2) |-> o_seg == ~$past(o_seg))
		else $error("segments not swapped with common");
endmodule
bind lgd_glass_drive lgd_glass_drive_checker #(.P_PHASE_CYC(P_PHASE_CYC)) u_chk (.i_clk, .i_rst_n, .i_low_power,
	.i_seg_pattern, .o_seg, .o_com, .o_com_oe, .o_glass_bias_supply, .o_phase_select_flag, .o_common_index, .o_dead_time);

// >>> testbench/lgd_glass_model.sv
// Glass model: net charge between segment 0 and common 0.
// Assumes logic-level pins; an unpowered glass discharges at once.
`timescale 1ns/1ps
module lgd_glass_model
(
	// Glass pins
	input  wire logic i_clk,
	input  wire logic i_seg0,
	input  wire logic i_com0,
	input  wire logic i_com0_oe,
	input  wire logic i_bias,
	// Net charge
	output int        o_dc
);
	initial
		o_dc = 0;
	// An undriven common sits at mid bias and adds no net charge
	always @(posedge i_clk)
		if (!i_bias)
			o_dc <= 0;
		else if (i_com0_oe)
			o_dc <= o_dc + int'(i_seg0) - int'(i_com0);
endmodule

// >>> testbench/tb.sv
// Bench for the glass drive: polarity, then duty rows, frame mode and low power.
// Assumes the drive is built with a 7352-cycle phase period.
`timescale 1ns/1ps
module tb;
	import lgd_pkg::*;
	typedef struct
	{
		logic [15:0] c;
		int          a;
	} lgd_row_t;
	logic                 i_clk = 1'b0;
	logic                 i_rst_n = 1'b0;
	logic [15:0]          i_contrast_setting = 16'h0000;
	logic                 i_dead_at_frame_end = 1'b0;
	logic                 i_low_power = 1'b0;
	logic [LGD_PAT_W-1:0] i_seg_pattern = {32'h0F0F_00FF, 32'h1234_5678, 32'hC3C3_5A5A, 32'h8001_F00D};
	logic [31:0]          o_seg;
	logic [3:0]           o_com;
	logic [3:0]           o_com_oe;
	logic                 o_glass_bias_supply;
	logic                 o_phase_select_flag;
	logic [1:0]           o_common_index;
	logic                 o_dead_time;
	int                   dc;
	int                   miscompares = 0;
	int                   n_checks = 0;
	int                   n;
	lgd_row_t             rows [4] = '{'{16'h0000, 7352}, '{16'h1000, 3256}, '{16'h1CB8, 0}, '{16'hFFFF, 0}};
	lgd_glass_drive #(.P_PHASE_CYC(7352)) u_dut (.i_clk, .i_rst_n, .i_contrast_setting, .i_dead_at_frame_end,
		.i_low_power, .i_seg_pattern, .o_seg, .o_com, .o_com_oe, .o_glass_bias_supply, .o_phase_select_flag,
		.o_common_index, .o_dead_time);
	lgd_glass_model u_glass (.i_clk, .i_seg0(o_seg[0]), .i_com0(o_com[0]), .i_com0_oe(o_com_oe[0]),
		.i_bias(o_glass_bias_supply), .o_dc(dc));
	initial
		forever #2.5 i_clk = ~i_clk;
	task automatic complete_run();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic next_phase();
		logic f;
		f = o_phase_select_flag;
		@(negedge i_clk);
		while (o_phase_select_flag === f)
			@(negedge i_clk);
	endtask
	// Off cycles count as active: only dead time is measured
	task automatic count_active(input int cyc, output int act);
		act = 0;
		repeat (cyc)
		begin
			@(negedge i_clk);
			if (o_dead_time === 1'b0)
				act++;
		end
	endtask
	initial
	begin
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		check_val({o_com_oe, o_glass_bias_supply, o_seg}, {4'hF, 1'b0, 32'h0});
		@(posedge i_clk) i_rst_n <= 1'b1;
		repeat (2) @(negedge i_clk);
		check_val({o_com_oe, o_com, o_seg}, {4'h1, 4'h1, ~i_seg_pattern[31:0]});
		next_phase();
		repeat (2) @(negedge i_clk);
		check_val({o_com_oe, o_com, o_seg}, {4'h1, 4'h0, i_seg_pattern[31:0]});
		foreach (rows[i])
		begin
			@(posedge i_clk) i_contrast_setting <= rows[i].c;
			next_phase();
			count_active(7352, n);
			check_val(n, rows[i].a);
		end
		@(posedge i_clk)
		begin
			i_contrast_setting <= 16'h1CB8;
			i_dead_at_frame_end <= 1'b1;
		end
		next_phase();
		@(posedge i_clk) i_low_power <= 1'b1;
		repeat (3) @(negedge i_clk);
		check_val({o_glass_bias_supply, o_seg, o_com, o_com_oe, o_phase_select_flag, o_common_index},
			{1'b0, 32'h0, 4'h0, 4'hF, 1'b0, 2'h0});
		@(posedge i_clk) i_low_power <= 1'b0;
		// Window covers exactly both halves of common 0, so the glass charge must net to zero
		repeat (2) @(negedge i_clk);
		count_active(14704, n);
		check_val(n, 14704);
		check_val(dc, 0);
		complete_run();
	end
	initial
	begin
		#475000;
		miscompares++;
		complete_run();
	end
endmodule
